// >>> src/aopc_map.svh
// Offsets, field positions, reset values and frame sizes of the output pattern bank.
`ifndef AOPC_MAP_SVH
`define AOPC_MAP_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define AOPC_OFS_FORMAT     8'h0D
`define AOPC_OFS_SCRAMBLE   8'h12
`define AOPC_OFS_A_CTRL     8'h13
`define AOPC_OFS_A_P0_LOW   8'h14
`define AOPC_OFS_A_MIXED    8'h15
`define AOPC_OFS_A_P1_HIGH  8'h16
`define AOPC_OFS_B_CTRL     8'h18

// ********************************************************************
// Field positions
// ********************************************************************
`define AOPC_FORMAT_BIT     13
`define AOPC_GAIN_HI        8
`define AOPC_GAIN_LO        7
`define AOPC_SCRAMBLE_BIT   3
`define AOPC_STEP_HI        7
`define AOPC_STEP_LO        4
`define AOPC_MODE_HI        3
`define AOPC_MODE_LO        2
`define AOPC_ENABLE_BIT     1

// ********************************************************************
// Reset values and constants
// ********************************************************************
`define AOPC_RST_FORMAT     16'h2002
`define AOPC_RST_SCRAMBLE   16'h0002
`define AOPC_RST_PATTERN    16'h0000
`define AOPC_GAIN_ON        2'h3
`define AOPC_FRAME_LAST     5'h17
`define AOPC_SIGN_FLIP      18'h20000

`endif

// >>> src/aopc_pkg.sv
// Types shared by the output pattern bank.
package aopc_pkg;

    typedef enum logic [1:0] {
        AOPC_FIXED0     = 2'h0,
        AOPC_FIXED0_ALT = 2'h1,
        AOPC_RAMP       = 2'h2,
        AOPC_ALTERNATE  = 2'h3
    } aopc_mode_t;

    typedef logic [23:0] aopc_word_t;
    typedef logic [17:0] aopc_result_t;

endpackage : aopc_pkg

// >>> src/aopc_pattern_gen.sv
// Per-channel test pattern generator: fixed, alternating and ramp words.
`timescale 1ns/100ps
`include "aopc_map.svh"

module aopc_pattern_gen
    import aopc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Sample timing
    input  wire logic       sample_strobe,
    // Controls
    input  wire logic [3:0] ramp_step,
    input  wire logic [1:0] pattern_select,
    input  wire aopc_word_t fixed_word0,
    input  wire aopc_word_t fixed_word1,
    // Generated pattern
    output aopc_word_t      pattern_word
);

    aopc_word_t ramp_reg;
    logic       alt_reg;

    // ********************************************************************
    // Ramp and alternation state
    // ********************************************************************
    // The ramp restarts at zero whenever another mode is chosen, so a
    // fresh ramp always begins from a known value.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ramp_reg <= 24'h000000;
        end else if (aopc_mode_t'(pattern_select) != AOPC_RAMP) begin
            ramp_reg <= 24'h000000;
        end else if (sample_strobe) begin
            ramp_reg <= ramp_reg + {20'h00000, ramp_step} + 24'h000001; // [RULE4] [RULE14]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alt_reg <= 1'b0;
        end else if (aopc_mode_t'(pattern_select) != AOPC_ALTERNATE) begin
            alt_reg <= 1'b0;
        end else if (sample_strobe) begin
            alt_reg <= ~alt_reg; // [RULE14]
        end
    end

    // ********************************************************************
    // Pattern selection
    // ********************************************************************
    always_comb begin
        unique case (aopc_mode_t'(pattern_select)) // [RULE5]
            AOPC_FIXED0, AOPC_FIXED0_ALT: pattern_word = fixed_word0;
            AOPC_RAMP:                    pattern_word = ramp_reg;
            AOPC_ALTERNATE:               pattern_word = alt_reg ? fixed_word1 : fixed_word0;
        endcase
    end

endmodule : aopc_pattern_gen

// >>> src/aopc_bank.sv
// Output format, scrambling and test pattern register bank on the SPI config port.
`timescale 1ns/100ps
`include "aopc_map.svh"

// Function
// RULE1 - Format bit picks offset binary or two's complement
// RULE2 - Gain field 0 disables, 3 enables correction
// RULE3 - Scramble XORs each word with its LSB
// RULE4 - Ramp advances by step plus one
// RULE5 - Mode: fixed0, fixed0, ramp, alternate
// RULE6 - Pattern enable swaps result for pattern
// RULE7 - Channel A pattern0 spans low register, mixed low
// RULE8 - Channel A pattern1 spans mixed high, high register
// RULE9 - Channel B has own control register
// RULE10 - Host keeps reserved fields at reset values
// RULE11 - Sixteen bit registers, all fields read back
// RULE12 - Host selects this bank before access
// RULE13 - Frames carry address byte then data word
// RULE14 - Ramp wraps, alternate toggles each sample
module aopc_bank
    import aopc_pkg::*;
(
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   rstn,
    // SPI configuration port
    input  wire logic   cs_n,
    input  wire logic   sclk,
    input  wire logic   sdi,
    output logic        sdo,
    // Bank 0 state
    input  wire logic   bank_selected,
    input  wire logic   read_enable,
    // Conversion results
    input  wire logic   sample_strobe,
    input  aopc_result_t adc_a_result,
    input  aopc_result_t adc_b_result,
    // Output words
    output aopc_word_t  chan_a_word,
    output aopc_word_t  chan_b_word,
    output logic        word_valid,
    // Global controls
    output logic        data_twos_complement,
    output logic        gain_correction_enable
);

    logic [15:0] format_reg;
    logic [15:0] scramble_reg;
    logic [15:0] a_ctrl_reg;
    logic [15:0] a_p0_low_reg;
    logic [15:0] a_mixed_reg;
    logic [15:0] a_p1_high_reg;
    logic [15:0] b_ctrl_reg;
    logic [22:0] shift_in_reg;
    logic [23:0] shift_out_reg;
    logic [4:0]  bit_cnt_reg;
    logic        sclk_prev_reg;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        frame_done;
    logic [23:0] frame_word;
    logic        wr_en;
    logic [15:0] rd_data;
    aopc_word_t  chan_a_fixed_word0;
    aopc_word_t  chan_a_fixed_word1;
    aopc_word_t  chan_b_fixed_word0;
    aopc_word_t  chan_b_fixed_word1;
    aopc_word_t  chan_a_pattern;
    aopc_word_t  chan_b_pattern;
    logic        chan_a_pattern_enable;
    logic        chan_b_pattern_enable;

    // Reformat a signed conversion result and optionally scramble it.
    function automatic aopc_result_t shape_result(aopc_result_t raw, logic twos, logic scr);
        aopc_result_t w;
        w = twos ? raw : (raw ^ `AOPC_SIGN_FLIP); // [RULE1]
        if (scr) begin
            w = w ^ {18{w[0]}}; // [RULE3]
        end
        return w;
    endfunction : shape_result

    // ********************************************************************
    // Serial frame reception
    // ********************************************************************
    // The serial clock is sampled by mclk, so it must run at no more than
    // half the mclk rate, each level lasting a cycle; faster edges would be missed.
    assign sclk_rise  = sclk & ~sclk_prev_reg;
    assign sclk_fall  = ~sclk & sclk_prev_reg;
    assign frame_done = ~cs_n & sclk_rise & (bit_cnt_reg == `AOPC_FRAME_LAST);
    assign frame_word = {shift_in_reg, sdi}; // [RULE13]
    assign wr_en      = frame_done & bank_selected & ~read_enable; // [RULE12]

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_reg  <= 5'h00;
            shift_in_reg <= 23'h000000;
        end else if (cs_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            shift_in_reg <= frame_word[22:0];
            bit_cnt_reg  <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01;
        end
    end

    // ********************************************************************
    // Register writes
    // ********************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            format_reg    <= `AOPC_RST_FORMAT; // [RULE1] [RULE10]
            scramble_reg  <= `AOPC_RST_SCRAMBLE;
            a_ctrl_reg    <= `AOPC_RST_PATTERN; // [RULE11]
            a_p0_low_reg  <= `AOPC_RST_PATTERN;
            a_mixed_reg   <= `AOPC_RST_PATTERN;
            a_p1_high_reg <= `AOPC_RST_PATTERN;
            b_ctrl_reg    <= `AOPC_RST_PATTERN;
        end else if (wr_en) begin
            unique case (frame_word[23:16])
                `AOPC_OFS_FORMAT:    format_reg    <= frame_word[15:0];
                `AOPC_OFS_SCRAMBLE:  scramble_reg  <= frame_word[15:0];
                `AOPC_OFS_A_CTRL:    a_ctrl_reg    <= frame_word[15:0];
                `AOPC_OFS_A_P0_LOW:  a_p0_low_reg  <= frame_word[15:0];
                `AOPC_OFS_A_MIXED:   a_mixed_reg   <= frame_word[15:0];
                `AOPC_OFS_A_P1_HIGH: a_p1_high_reg <= frame_word[15:0];
                `AOPC_OFS_B_CTRL:    b_ctrl_reg    <= frame_word[15:0]; // [RULE9]
                default: ;
            endcase
        end
    end

    // ********************************************************************
    // Register reads
    // ********************************************************************
    // Every bit is stored as written, reserved ones included, so readback
    // returns exactly what the host last wrote.
    always_comb begin
        unique case (frame_word[23:16]) // [RULE11]
            `AOPC_OFS_FORMAT:    rd_data = format_reg;
            `AOPC_OFS_SCRAMBLE:  rd_data = scramble_reg;
            `AOPC_OFS_A_CTRL:    rd_data = a_ctrl_reg;
            `AOPC_OFS_A_P0_LOW:  rd_data = a_p0_low_reg;
            `AOPC_OFS_A_MIXED:   rd_data = a_mixed_reg;
            `AOPC_OFS_A_P1_HIGH: rd_data = a_p1_high_reg;
            `AOPC_OFS_B_CTRL:    rd_data = b_ctrl_reg;
            default:             rd_data = 16'h0000;
        endcase
    end

    // A read frame loads address and data; they leave on the next frame,
    // MSB first, changing on falling serial clock edges.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shift_out_reg <= 24'h000000;
        end else if (frame_done & bank_selected & read_enable) begin
            shift_out_reg <= {frame_word[23:16], rd_data}; // [RULE13]
        end else if (~cs_n & sclk_fall & (bit_cnt_reg != 5'h00)) begin
            shift_out_reg <= {shift_out_reg[22:0], 1'b0};
        end
    end

    assign sdo = shift_out_reg[23];

    // ********************************************************************
    // Pattern words and generators
    // ********************************************************************
    assign chan_a_fixed_word0    = {a_mixed_reg[7:0], a_p0_low_reg}; // [RULE7]
    assign chan_a_fixed_word1    = {a_p1_high_reg, a_mixed_reg[15:8]}; // [RULE8]
    assign chan_b_fixed_word0    = 24'h000000;
    assign chan_b_fixed_word1    = 24'h000000;
    assign chan_a_pattern_enable = a_ctrl_reg[`AOPC_ENABLE_BIT];
    assign chan_b_pattern_enable = b_ctrl_reg[`AOPC_ENABLE_BIT];

    aopc_pattern_gen u_gen_a (
        .mclk           (mclk),
        .rstn           (rstn),
        .sample_strobe  (sample_strobe),
        .ramp_step      (a_ctrl_reg[`AOPC_STEP_HI:`AOPC_STEP_LO]),
        .pattern_select (a_ctrl_reg[`AOPC_MODE_HI:`AOPC_MODE_LO]),
        .fixed_word0    (chan_a_fixed_word0),
        .fixed_word1    (chan_a_fixed_word1),
        .pattern_word   (chan_a_pattern)
    );

    aopc_pattern_gen u_gen_b (
        .mclk           (mclk),
        .rstn           (rstn),
        .sample_strobe  (sample_strobe),
        .ramp_step      (b_ctrl_reg[`AOPC_STEP_HI:`AOPC_STEP_LO]), // [RULE9]
        .pattern_select (b_ctrl_reg[`AOPC_MODE_HI:`AOPC_MODE_LO]),
        .fixed_word0    (chan_b_fixed_word0),
        .fixed_word1    (chan_b_fixed_word1),
        .pattern_word   (chan_b_pattern)
    );

    // ********************************************************************
    // Output data path
    // ********************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chan_a_word <= 24'h000000;
            chan_b_word <= 24'h000000;
        end else if (sample_strobe) begin
            chan_a_word <= chan_a_pattern_enable ? chan_a_pattern : // [RULE6]
                {6'h00, shape_result(adc_a_result, format_reg[`AOPC_FORMAT_BIT],
                                     scramble_reg[`AOPC_SCRAMBLE_BIT])};
            chan_b_word <= chan_b_pattern_enable ? chan_b_pattern : // [RULE6]
                {6'h00, shape_result(adc_b_result, format_reg[`AOPC_FORMAT_BIT],
                                     scramble_reg[`AOPC_SCRAMBLE_BIT])};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            word_valid <= 1'b0;
        end else begin
            word_valid <= sample_strobe;
        end
    end

    assign data_twos_complement   = format_reg[`AOPC_FORMAT_BIT]; // [RULE1]
    assign gain_correction_enable =
        (format_reg[`AOPC_GAIN_HI:`AOPC_GAIN_LO] == `AOPC_GAIN_ON); // [RULE2]

endmodule : aopc_bank

// >>> verif/aopc_monitor.sv
// Port checker for the output pattern bank.
`timescale 1ns/100ps
module aopc_monitor
    import aopc_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // SPI port and bank state
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       sdo,
    input wire logic       bank_selected,
    input wire logic       read_enable,
    // Data path and controls
    input wire logic       sample_strobe,
    input wire aopc_word_t chan_a_word,
    input wire aopc_word_t chan_b_word,
    input wire logic       word_valid,
    input wire logic       data_twos_complement,
    input wire logic       gain_correction_enable
);
    // ****************************************************************
    // Port relations
    // ****************************************************************
    // Controls may only move on a write frame, so cycles with chip select high, the bank deselected or read_enable set must hold them.
    default clocking mon_clk @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_RESET_VAL:
        assert property (!$past(rstn) |-> data_twos_complement && !gain_correction_enable
            && !word_valid && chan_a_word == 24'h000000) else $error("bad reset outputs");
    AST_VALID_CAUSE:
        assert property (sample_strobe |=> word_valid) else $error("valid missing");
    AST_VALID_PULSE:
        assert property (word_valid |-> $past(sample_strobe)) else $error("stray valid");
    AST_A_HOLD:
        assert property (!sample_strobe |=> $stable(chan_a_word)) else $error("a word moved");
    AST_B_HOLD:
        assert property (!sample_strobe |=> $stable(chan_b_word)) else $error("b word moved");
    AST_FMT_HOLD:
        assert property ((cs_n || !bank_selected || read_enable) |=> $stable(data_twos_complement))
        else $error("format moved");
    AST_GAIN_HOLD:
        assert property ((cs_n || !bank_selected || read_enable) |=>
            $stable(gain_correction_enable)) else $error("gain moved");
    AST_SDO_HOLD:
        assert property ((cs_n || sclk == $past(sclk)) |=> $stable(sdo)) else $error("sdo moved");
endmodule : aopc_monitor

bind aopc_bank aopc_monitor mon (
    .mclk                   (mclk),
    .rstn                   (rstn),
    .cs_n                   (cs_n),
    .sclk                   (sclk),
    .sdo                    (sdo),
    .bank_selected          (bank_selected),
    .read_enable            (read_enable),
    .sample_strobe          (sample_strobe),
    .chan_a_word            (chan_a_word),
    .chan_b_word            (chan_b_word),
    .word_valid             (word_valid),
    .data_twos_complement   (data_twos_complement),
    .gain_correction_enable (gain_correction_enable)
);

// >>> verif/aopc_host_model.sv
// Host controller model driving the SPI configuration port.
`timescale 1ns/100ps
module aopc_host_model (
    // Clock
    input wire logic  mclk,
    // SPI port
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input wire logic  sdo
);
    // ****************************************************************
    // Frame driver
    // ****************************************************************
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // Called at a falling edge; each sclk level lasts two cycles, though the port's edge detector needs only one.
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            sdi  = tx[i];
            repeat (2) @(negedge mclk);
            rx   = {rx[22:0], sdo};
            sclk = 1'b1;
            repeat (2) @(negedge mclk);
        end
        sclk = 1'b0;
        sdi  = ~sdi;
        repeat (2) @(negedge mclk);
        cs_n = 1'b1;
        repeat (2) @(negedge mclk);
    endtask : frame
    // Sends only the first twelve bits and then lifts chip select, so the frame is cut short.
    task automatic cut(input logic [23:0] tx);
        cs_n = 1'b0;
        for (int i = 23; i >= 12; i--) begin
            sclk = 1'b0;
            sdi  = tx[i];
            repeat (2) @(negedge mclk);
            sclk = 1'b1;
            repeat (2) @(negedge mclk);
        end
        sclk = 1'b0;
        repeat (2) @(negedge mclk);
        cs_n = 1'b1;
        repeat (2) @(negedge mclk);
    endtask : cut
endmodule : aopc_host_model

// >>> verif/testbench.sv
// Self-checking bench for the output pattern bank.
`timescale 1ns/100ps
`include "aopc_map.svh"
module testbench;
    import aopc_pkg::*;
    logic         mclk, rstn, bank_selected, read_enable, sample_strobe, sdo, word_valid;
    logic         cs_n, sclk, sdi, data_twos_complement, gain_correction_enable;
    aopc_result_t adc_a_result, adc_b_result;
    aopc_word_t   chan_a_word, chan_b_word, bv;
    logic [23:0]  rx, ctl;
    int           miscompares, n_tests;
    logic [7:0]   ofs [7] = '{8'h0D, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18};
    logic [15:0]  rst [7] = '{16'h2002, 16'h0002, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0]  wv [7] = '{16'h2182, 16'h0002, 16'h00F2, 16'h3456, 16'hBC12, 16'h789A, 16'h000A};

    aopc_bank dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .bank_selected(bank_selected), .read_enable(read_enable), .sample_strobe(sample_strobe),
        .adc_a_result(adc_a_result), .adc_b_result(adc_b_result), .chan_a_word(chan_a_word),
        .chan_b_word(chan_b_word), .word_valid(word_valid),
        .data_twos_complement(data_twos_complement),
        .gain_correction_enable(gain_correction_enable));
    aopc_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
    assign ctl = {22'h000000, data_twos_complement, gain_correction_enable};

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        read_enable = 1'b0;
        host.frame({a, d}, rx);
    endtask : wr
    // The answer comes out on the frame after the address frame.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        read_enable = 1'b1;
        host.frame({a, 16'h0000}, rx);
        host.frame(24'hFFFFFF, rx);
        chk("register read", rx, {a, exp});
    endtask : rd
    task automatic smp(input aopc_result_t a, input aopc_word_t ea, input aopc_word_t eb);
        adc_a_result  = a;
        adc_b_result  = a;
        sample_strobe = 1'b1;
        @(negedge mclk);
        sample_strobe = 1'b0;
        chk("word_valid", {23'h000000, word_valid}, 24'h000001);
        chk("chan_a_word", chan_a_word, ea);
        chk("chan_b_word", chan_b_word, eb);
        @(negedge mclk);
    endtask : smp
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        rstn          = 1'b0;
        bank_selected = 1'b1;
        read_enable   = 1'b0;
        sample_strobe = 1'b0;
        adc_a_result  = 18'h00000;
        adc_b_result  = 18'h00000;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        for (int i = 0; i < 7; i++) rd(ofs[i], rst[i]);
        rd(8'h17, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 7; i++) begin
            wr(ofs[i], wv[i]);
            rd(ofs[i], wv[i]);
        end
        chk("controls", ctl, 24'h3);
        wr(`AOPC_OFS_FORMAT, 16'h2102);
        chk("controls", ctl, 24'h2);
        wr(`AOPC_OFS_FORMAT, 16'h2082);
        chk("controls", ctl, 24'h2);
        $display("test readback done");
        bv = 24'h000000;
        for (int i = 0; i < 3; i++) begin
            smp(18'h00005, 24'h123456, bv);
            bv++;
        end
        wr(`AOPC_OFS_A_CTRL, 16'h0006);
        smp(18'h00005, 24'h123456, bv);
        bv++;
        wr(`AOPC_OFS_A_CTRL, 16'h000E);
        for (int i = 0; i < 3; i++) begin
            smp(18'h00005, i[0] ? 24'h789ABC : 24'h123456, bv);
            bv++;
        end
        wr(`AOPC_OFS_A_CTRL, 16'h00FA);
        for (int i = 0; i < 3; i++) begin
            smp(18'h00005, 24'(i * 16), bv);
            bv++;
        end
        $display("test patterns done");
        wr(`AOPC_OFS_A_CTRL, 16'h0000);
        wr(`AOPC_OFS_B_CTRL, 16'h0000);
        smp(18'h3FFFF, 24'h03FFFF, 24'h03FFFF);
        wr(`AOPC_OFS_FORMAT, 16'h0002);
        chk("controls", ctl, 24'h0);
        smp(18'h3FFFF, 24'h01FFFF, 24'h01FFFF);
        wr(`AOPC_OFS_SCRAMBLE, 16'h000A);
        smp(18'h00005, 24'h01FFFA, 24'h01FFFA);
        smp(18'h00004, 24'h020004, 24'h020004);
        $display("test format done");
        bank_selected = 1'b0;
        wr(`AOPC_OFS_A_CTRL, 16'h00F2);
        bank_selected = 1'b1;
        rd(`AOPC_OFS_A_CTRL, 16'h0000);
        // A cut frame must write nothing and must leave the bit count cleared.
        host.cut({`AOPC_OFS_A_CTRL, 16'h00F2});
        rd(`AOPC_OFS_A_CTRL, 16'h0000);
        $display("test bank select done");
        print_verdict();
    end
endmodule : testbench
